/* rtl/vtp_urb_reader.sv */
/*
  Vertex thread payload reader: fetches constant and vertex rows from the
  unified return buffer and hands them out as numbered thread registers.
  Assumes an AXI4-Lite master on the register port, a buffer read port that
  answers each accepted address with exactly one row in order, and a payload
  sink that may stall.
*/
`timescale 1ns/1ps

// What this block does
// - Constant read starts at programmed constant offset
// - Each vertex reads programmed count of rows
// - Vertex read starts at programmed vertex offset
// - Same vertex offset used for every entry
// - Payload begins at programmed start register
// - Disabled stage ignores all payload read fields
// - Constant block length comes from its field
module vtp_urb_reader (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic urb_rd_valid,
  input wire logic urb_rd_ready,
  output logic [vtp_pkg::ADDR_W-1:0] urb_rd_addr,
  input wire logic urb_rsp_valid,
  output logic urb_rsp_ready,
  input wire logic [vtp_pkg::DATA_W-1:0] urb_rsp_data,
  output logic pay_valid,
  input wire logic pay_ready,
  output logic [vtp_pkg::CNT_W-1:0] pay_reg,
  output logic [vtp_pkg::DATA_W-1:0] pay_data,
  output logic pay_last
);

  localparam int AW = vtp_pkg::ADDR_W;
  localparam int CW = vtp_pkg::CNT_W;

  typedef enum logic [1:0] {
    S_IDLE,
    S_CONST,
    S_VERT,
    S_DRAIN
  } vtp_seq_t;

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] desc_word;
    logic func_on;
    logic [AW-1:0] const_base;
    logic [AW-1:0] vert_base;
    logic [AW-1:0] vert_stride;
    vtp_seq_t seq;
    vtp_pkg::vtp_desc_t cur;
    logic [vtp_pkg::VCNT_W-1:0] nv_m1;
    logic [vtp_pkg::VCNT_W-1:0] v;
    logic [vtp_pkg::FIELD_W-1:0] i;
    logic [AW-1:0] addr;
    logic [AW-1:0] ebase;
    logic [AW-1:0] stride;
    logic [CW-1:0] issued;
    logic [CW-1:0] popped;
    logic [CW-1:0] total;
    logic [31:0] threads;
  } vtp_st_t;

  localparam vtp_st_t ST_RST = '{
    desc_word: vtp_pkg::DESC_RST,
    func_on: vtp_pkg::CTRL_FUNC_RST,
    const_base: vtp_pkg::CONST_BASE_RST,
    vert_base: vtp_pkg::VERT_BASE_RST,
    vert_stride: vtp_pkg::VERT_STRIDE_RST,
    seq: S_IDLE,
    default: '0
  };

  vtp_st_t s_reg;
  vtp_st_t s_next;
  vtp_pkg::vtp_desc_t dec;
  logic fifo_out_valid;
  logic [vtp_pkg::LVL_W-1:0] fifo_level;
  logic [CW-1:0] in_flight;
  logic issue;
  logic pop;
  logic wr_fire;
  logic [7:0] wr_off;
  logic [31:0] wr_val;
  logic wr_ok;
  logic [31:0] rd_val;
  logic rd_ok;

  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction

  vtp_field_decode i_vtp_field_decode (
    .desc_word(s_reg.desc_word),
    .vertex_stage_function_on(s_reg.func_on),
    .desc(dec)
  );

  // Return rows land here; pay_ready back-pressure stalls the buffer reads
  vtp_fifo #(
    .WIDTH(vtp_pkg::DATA_W),
    .DEPTH(vtp_pkg::FIFO_DEPTH),
    .LVL_W(vtp_pkg::LVL_W)
  ) i_vtp_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(urb_rsp_valid),
    .in_ready(urb_rsp_ready),
    .in_data(urb_rsp_data),
    .out_valid(fifo_out_valid),
    .out_ready(pay_ready),
    .out_data(pay_data),
    .level(fifo_level)
  );

  assign s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_held && !s_reg.bvalid;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;

  // Rows requested but not yet handed out; capped so the FIFO never overflows
  assign in_flight = s_reg.issued - s_reg.popped;
  assign urb_rd_valid = (s_reg.seq == S_CONST || s_reg.seq == S_VERT) &&
                        (in_flight < CW'(vtp_pkg::FIFO_DEPTH));
  assign urb_rd_addr = s_reg.addr;
  assign issue = urb_rd_valid && urb_rd_ready;

  assign pay_valid = fifo_out_valid;
  assign pop = pay_valid && pay_ready;
  assign pay_reg = CW'(s_reg.cur.start_reg) + s_reg.popped;
  assign pay_last = s_reg.popped == (s_reg.total - 1'b1);

  assign wr_fire = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
  assign wr_off = {s_reg.aw_addr[7:2], 2'b00};

  // Write decode: new value of the addressed register and whether it exists
  always_comb begin
    wr_ok = 1'b1;
    wr_val = '0;
    unique case (wr_off)
      vtp_pkg::OFF_DESC: begin
        wr_val = merge_bytes(s_reg.desc_word, s_reg.wdata, s_reg.wstrb) & vtp_pkg::DESC_MASK;
      end
      vtp_pkg::OFF_CTRL: begin
        wr_val = merge_bytes({31'h0, s_reg.func_on}, s_reg.wdata, s_reg.wstrb);
      end
      vtp_pkg::OFF_CONST_BASE: begin
        wr_val = merge_bytes({22'h0, s_reg.const_base}, s_reg.wdata, s_reg.wstrb);
      end
      vtp_pkg::OFF_VERT_BASE: begin
        wr_val = merge_bytes({22'h0, s_reg.vert_base}, s_reg.wdata, s_reg.wstrb);
      end
      vtp_pkg::OFF_VERT_STRIDE: begin
        wr_val = merge_bytes({22'h0, s_reg.vert_stride}, s_reg.wdata, s_reg.wstrb);
      end
      vtp_pkg::OFF_DISPATCH: begin
        wr_val = s_reg.wdata;
      end
      vtp_pkg::OFF_STATUS, vtp_pkg::OFF_THREADS: begin
        wr_val = '0;
      end
      default: begin
        wr_ok = 1'b0;
      end
    endcase
  end

  // Read decode
  always_comb begin
    rd_ok = 1'b1;
    rd_val = '0;
    unique case ({s_axi_araddr[7:2], 2'b00})
      vtp_pkg::OFF_DESC: rd_val = s_reg.desc_word;
      vtp_pkg::OFF_CTRL: rd_val = {31'h0, s_reg.func_on};
      vtp_pkg::OFF_CONST_BASE: rd_val = {22'h0, s_reg.const_base};
      vtp_pkg::OFF_VERT_BASE: rd_val = {22'h0, s_reg.vert_base};
      vtp_pkg::OFF_VERT_STRIDE: rd_val = {22'h0, s_reg.vert_stride};
      vtp_pkg::OFF_DISPATCH: rd_val = '0;
      vtp_pkg::OFF_STATUS: begin
        rd_val[vtp_pkg::STAT_BUSY_BIT] = s_reg.seq != S_IDLE;
        rd_val[vtp_pkg::STAT_FUNC_BIT] = s_reg.func_on;
        rd_val[vtp_pkg::STAT_LVL_LSB +: vtp_pkg::LVL_W] = fifo_level;
      end
      vtp_pkg::OFF_THREADS: rd_val = s_reg.threads;
      default: rd_ok = 1'b0;
    endcase
    if (s_axi_araddr[31:8] != '0) begin
      rd_ok = 1'b0;
      rd_val = '0;
    end
  end

  always_comb begin
    s_next = s_reg;

    // Register port
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_held = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_val;
      s_next.rresp = rd_ok ? vtp_pkg::RESP_OKAY : vtp_pkg::RESP_SLVERR;
    end

    if (wr_fire) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = wr_ok ? vtp_pkg::RESP_OKAY : vtp_pkg::RESP_SLVERR;
      unique case (wr_off)
        vtp_pkg::OFF_DESC: s_next.desc_word = wr_val;
        vtp_pkg::OFF_CTRL: s_next.func_on = wr_val[vtp_pkg::CTRL_FUNC_ON_BIT];
        vtp_pkg::OFF_CONST_BASE: s_next.const_base = wr_val[AW-1:0];
        vtp_pkg::OFF_VERT_BASE: s_next.vert_base = wr_val[AW-1:0];
        vtp_pkg::OFF_VERT_STRIDE: s_next.vert_stride = wr_val[AW-1:0];
        default: ;
      endcase
    end

    // Dispatch: fields are frozen for the whole thread; ignored while busy
    if (wr_fire && wr_off == vtp_pkg::OFF_DISPATCH && s_reg.wstrb[0] &&
        s_reg.seq == S_IDLE) begin
      s_next.cur = dec;
      s_next.nv_m1 = s_reg.wdata[vtp_pkg::VCNT_W-1:0];
      s_next.issued = '0;
      s_next.popped = '0;
      s_next.i = '0;
      s_next.v = '0;
      s_next.ebase = s_reg.vert_base;
      s_next.stride = s_reg.vert_stride;
      s_next.total = CW'(dec.const_len) +
                     CW'(CW'({1'b0, s_reg.wdata[vtp_pkg::VCNT_W-1:0]}) + 1'b1) *
                     CW'(dec.vert_len);
      if (!s_reg.func_on) begin
        // Nothing is read for a disabled stage
        s_next.seq = S_DRAIN;
      end else if (dec.const_len == '0) begin
        s_next.seq = S_VERT;
        s_next.addr = s_reg.vert_base + AW'(dec.vert_off);
      end else begin
        s_next.seq = S_CONST;
        s_next.addr = s_reg.const_base + AW'(dec.const_off);
      end
    end

    // Row address walk
    if (issue) begin
      s_next.issued = s_reg.issued + 1'b1;
      if (s_reg.seq == S_CONST) begin
        if (s_reg.i == s_reg.cur.const_len - 1'b1) begin
          s_next.seq = S_VERT;
          s_next.i = '0;
          s_next.addr = s_reg.ebase + AW'(s_reg.cur.vert_off);
        end else begin
          s_next.i = s_reg.i + 1'b1;
          s_next.addr = s_reg.addr + 1'b1;
        end
      end else begin
        // A zero vertex length would wrap this compare; software must not program it
        if (s_reg.i == s_reg.cur.vert_len - 1'b1) begin
          if (s_reg.v == s_reg.nv_m1) begin
            s_next.seq = S_DRAIN;
          end else begin
            s_next.v = s_reg.v + 1'b1;
            s_next.i = '0;
            s_next.ebase = s_reg.ebase + s_reg.stride;
            s_next.addr = s_reg.ebase + s_reg.stride + AW'(s_reg.cur.vert_off);
          end
        end else begin
          s_next.i = s_reg.i + 1'b1;
          s_next.addr = s_reg.addr + 1'b1;
        end
      end
    end

    // Payload hand-out
    if (pop) begin
      s_next.popped = s_reg.popped + 1'b1;
    end
    if (s_reg.seq == S_DRAIN && s_reg.popped == s_reg.total) begin
      s_next.seq = S_IDLE;
      s_next.threads = s_reg.threads + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= ST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

/* pkg/vtp_pkg.sv */
/*
  Shared constants and types for the vertex thread payload reader.
  Assumes a 32-bit AXI4-Lite register port and 256-bit return buffer rows.
*/
package vtp_pkg;

  // Datapath sizes
  localparam int DATA_W = 256;
  localparam int FIFO_DEPTH = 32;
  localparam int LVL_W = 6;
  localparam int ADDR_W = 10;
  localparam int CNT_W = 10;
  localparam int VCNT_W = 3;
  localparam int FIELD_W = 6;
  localparam int START_W = 4;

  // Register byte offsets
  localparam logic [7:0] OFF_DESC = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_CONST_BASE = 8'h08;
  localparam logic [7:0] OFF_VERT_BASE = 8'h0c;
  localparam logic [7:0] OFF_VERT_STRIDE = 8'h10;
  localparam logic [7:0] OFF_DISPATCH = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_THREADS = 8'h1c;

  // Descriptor word field positions
  localparam int CLEN_LSB = 25;
  localparam int COFF_LSB = 18;
  localparam int VLEN_LSB = 11;
  localparam int VOFF_LSB = 4;
  localparam int START_LSB = 0;
  localparam logic [31:0] DESC_MASK = 32'h7efdfbff;

  // Control and status bit positions
  localparam int CTRL_FUNC_ON_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FUNC_BIT = 1;
  localparam int STAT_LVL_LSB = 8;

  // Reset values
  localparam logic [31:0] DESC_RST = 32'h00000800;
  localparam logic CTRL_FUNC_RST = 1'b0;
  localparam logic [ADDR_W-1:0] CONST_BASE_RST = 10'h000;
  localparam logic [ADDR_W-1:0] VERT_BASE_RST = 10'h000;
  localparam logic [ADDR_W-1:0] VERT_STRIDE_RST = 10'h040;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [FIELD_W-1:0] const_len;
    logic [FIELD_W-1:0] const_off;
    logic [FIELD_W-1:0] vert_len;
    logic [FIELD_W-1:0] vert_off;
    logic [START_W-1:0] start_reg;
  } vtp_desc_t;

endpackage

/* rtl/vtp_field_decode.sv */
/*
  Splits the vertex-stage descriptor word into its payload read fields.
  Assumes the word and the stage enable come from registers on the same clock.
*/
`timescale 1ns/1ps
module vtp_field_decode (
  input wire logic [31:0] desc_word,
  input wire logic vertex_stage_function_on,
  output vtp_pkg::vtp_desc_t desc
);

  // A disabled stage yields all-zero fields, so nothing downstream can act on them
  always_comb begin
    desc = '0;
    if (vertex_stage_function_on) begin
      desc.const_len = desc_word[vtp_pkg::CLEN_LSB +: vtp_pkg::FIELD_W];
      desc.const_off = desc_word[vtp_pkg::COFF_LSB +: vtp_pkg::FIELD_W];
      desc.vert_len = desc_word[vtp_pkg::VLEN_LSB +: vtp_pkg::FIELD_W];
      desc.vert_off = desc_word[vtp_pkg::VOFF_LSB +: vtp_pkg::FIELD_W];
      desc.start_reg = desc_word[vtp_pkg::START_LSB +: vtp_pkg::START_W];
    end
  end

endmodule

/* rtl/vtp_fifo.sv */
/*
  Synchronous FIFO with valid/ready on both sides and a fill level.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module vtp_fifo #(
  parameter int WIDTH = 256,
  parameter int DEPTH = 32,
  parameter int LVL_W = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LVL_W-1:0] level
);

  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [LVL_W-1:0] cnt;
  } vtp_fifo_st_t;

  vtp_fifo_st_t s_reg;
  vtp_fifo_st_t s_next;
  logic push;
  logic pop;

  assign in_ready = s_reg.cnt != LVL_W'(DEPTH);
  assign out_valid = s_reg.cnt != '0;
  assign out_data = s_reg.mem[s_reg.rd];
  assign level = s_reg.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr] = in_data;
      s_next.wr = (s_reg.wr == PTR_W'(DEPTH - 1)) ? '0 : s_reg.wr + 1'b1;
    end
    if (pop) begin
      s_next.rd = (s_reg.rd == PTR_W'(DEPTH - 1)) ? '0 : s_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  // Only pointers and level need a reset; stale words are never presented
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg.wr <= '0;
      s_reg.rd <= '0;
      s_reg.cnt <= '0;
      s_reg.mem <= s_next.mem;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

/* verification/vtp_urb_reader_sva.sv */
/*
  Port checker for the vertex thread payload reader.
  Assumes it is bound to vtp_urb_reader, one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module vtp_urb_reader_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic urb_rd_valid,
  input wire logic urb_rd_ready,
  input wire logic [vtp_pkg::ADDR_W-1:0] urb_rd_addr,
  input wire logic urb_rsp_valid,
  input wire logic urb_rsp_ready,
  input wire logic pay_valid,
  input wire logic pay_ready,
  input wire logic [vtp_pkg::CNT_W-1:0] pay_reg,
  input wire logic [vtp_pkg::DATA_W-1:0] pay_data,
  input wire logic pay_last
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic pend_reg;
  logic [vtp_pkg::CNT_W-1:0] nxt_reg;
  // Remembers the register number the next beat of the same thread must carry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_reg <= 1'b0;
      nxt_reg <= '0;
    end else if (pay_valid && pay_ready) begin
      pend_reg <= !pay_last;
      nxt_reg <= pay_reg + 10'h001;
    end
  end
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_req_holds: assert property (urb_rd_valid && !urb_rd_ready |=> urb_rd_valid && $stable(urb_rd_addr))
    else $error("row request changed before taken");
  a_pay_holds: assert property (pay_valid && !pay_ready
    |=> pay_valid && $stable({pay_reg, pay_last, pay_data})) else $error("beat changed while stalled");
  a_row_visible: assert property (urb_rsp_valid && urb_rsp_ready |=> pay_valid)
    else $error("stored row not offered");
  a_pay_contig: assert property (pay_valid && pend_reg |-> pay_reg == nxt_reg)
    else $error("payload register numbers not contiguous");
endmodule
bind vtp_urb_reader vtp_urb_reader_chk i_vtp_urb_reader_chk (.*);

/* verification/vtp_urb_model.sv */
/*
  Behavioural return buffer: answers each accepted row address once, in order.
  Assumes the reader's request and response handshakes share its clock.
*/
`timescale 1ns/1ps
module vtp_urb_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic urb_rd_valid,
  output logic urb_rd_ready,
  input wire logic [vtp_pkg::ADDR_W-1:0] urb_rd_addr,
  output logic urb_rsp_valid,
  input wire logic urb_rsp_ready,
  output logic [vtp_pkg::DATA_W-1:0] urb_rsp_data
);
  logic [vtp_pkg::ADDR_W-1:0] q[$];
  logic [vtp_pkg::ADDR_W-1:0] h;
  logic [3:0] t = 4'h0;
  always @(posedge aclk) begin
    t <= t + 4'h1;
    urb_rd_ready <= !slow || t[0];
    if (!aresetn) begin
      q.delete();
      urb_rsp_valid <= 1'b0;
      urb_rsp_data <= '0;
    end else begin
      if (urb_rd_valid && urb_rd_ready) q.push_back(urb_rd_addr);
      if (urb_rsp_valid && urb_rsp_ready) begin
        urb_rsp_valid <= 1'b0;
        // Released data must not keep looking like the last row
        urb_rsp_data <= ~urb_rsp_data;
      end else if (!urb_rsp_valid && q.size() > 0 && (!slow || t[1])) begin
        h = q.pop_front();
        urb_rsp_valid <= 1'b1;
        urb_rsp_data <= {16{6'h2a, h}};
      end
    end
  end
endmodule

/* verification/vtp_urb_reader_test.sv */
/*
  Testbench for the payload reader: AXI4-Lite register tasks and thread runs.
  Assumes the buffer model vtp_urb_model and a stalling payload sink.
*/
`timescale 1ns/1ps
module vtp_urb_reader_test;
  logic aclk, aresetn, slow, hold;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic urb_rd_valid, urb_rd_ready, urb_rsp_valid, urb_rsp_ready, pay_valid, pay_ready, pay_last;
  logic [9:0] urb_rd_addr, pay_reg;
  logic [255:0] urb_rsp_data, pay_data;
  int fails, n_checks, cyc;
  logic [9:0] got_reg[$];
  logic [255:0] got_dat[$];
  logic got_last[$];

  vtp_urb_reader i_vtp_urb_reader (.*);
  vtp_urb_model i_vtp_urb_model (.*);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  function automatic logic [255:0] row(input logic [9:0] a);
    return {16{6'h2a, a}};
  endfunction

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = vtp_pkg::RESP_OKAY);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      // Response taken one cycle late so a stalled answer is exercised too
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, output logic [33:0] rv);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    rv = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = vtp_pkg::RESP_OKAY);
    logic [33:0] rv;
    rd(a, rv);
    chk(rv, {er, e});
  endtask

  // Runs one thread and compares every beat with rows worked out from the fields
  task automatic thread(input logic [31:0] desc, input logic [2:0] nv, input logic on, input int hc);
    logic [9:0] ea[$];
    logic [33:0] st;
    got_reg.delete();
    got_dat.delete();
    got_last.delete();
    hold <= hc > 0;
    wr(vtp_pkg::OFF_DESC, desc);
    wr(vtp_pkg::OFF_CTRL, {31'h0, on});
    if (on) begin
      for (int i = 0; i < desc[30:25]; i++) ea.push_back(10'h010 + desc[23:18] + 10'(i));
      for (int v = 0; v <= nv; v++) begin
        for (int i = 0; i < desc[16:11]; i++) begin
          ea.push_back(10'h100 + 10'(v) * 10'h020 + desc[9:4] + 10'(i));
        end
      end
    end
    wr(vtp_pkg::OFF_DISPATCH, {29'h0, nv});
    if (hc > 0) begin
      repeat (hc) @(posedge aclk);
      // Sink stalled: buffer full at 32 rows and no further row requested
      rc(vtp_pkg::OFF_STATUS, 32'h00002003);
      hold <= 1'b0;
    end
    do rd(vtp_pkg::OFF_STATUS, st);
    while (st[0]);
    chk(got_dat.size(), ea.size());
    foreach (ea[k]) begin
      chk(got_dat[k], row(ea[k]));
      chk(got_reg[k], 10'(desc[3:0] + k));
      chk(got_last[k], k == ea.size() - 1);
    end
  endtask

  // Payload sink with a stall pattern, beat recorder and run timeout
  always @(posedge aclk) begin
    cyc++;
    pay_ready <= !hold && (cyc % 3 != 0);
    if (aresetn && pay_valid && pay_ready) begin
      got_reg.push_back(pay_reg);
      got_dat.push_back(pay_data);
      got_last.push_back(pay_last);
    end
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    {aresetn, slow, hold, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {fails, n_checks} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(vtp_pkg::OFF_DESC, 32'h00000800);
    rc(vtp_pkg::OFF_CTRL, 32'h0);
    rc(vtp_pkg::OFF_VERT_STRIDE, 32'h00000040);
    rc(8'h20, 32'h0, vtp_pkg::RESP_SLVERR);
    wr(8'h24, 32'h1, vtp_pkg::RESP_SLVERR);
    wr(vtp_pkg::OFF_DESC, 32'hffffffff);
    rc(vtp_pkg::OFF_DESC, vtp_pkg::DESC_MASK);
    // Byte strobes: only byte 1 of the stride lands; launching needs byte 0
    s_axi_wstrb <= 4'h2;
    wr(vtp_pkg::OFF_VERT_STRIDE, 32'h0000ff55);
    s_axi_wstrb <= 4'he;
    wr(vtp_pkg::OFF_DISPATCH, 32'h0);
    s_axi_wstrb <= 4'hf;
    rc(vtp_pkg::OFF_VERT_STRIDE, 32'h00000340);
    rc(vtp_pkg::OFF_THREADS, 32'h0);
    $display("test registers done");
    wr(vtp_pkg::OFF_CONST_BASE, 32'h010);
    wr(vtp_pkg::OFF_VERT_BASE, 32'h100);
    wr(vtp_pkg::OFF_VERT_STRIDE, 32'h020);
    slow <= 1'b1;
    // Vertex length never zero in any descriptor here
    thread({1'b0, 6'd2, 1'b0, 6'd5, 1'b0, 6'd3, 1'b0, 6'd7, 4'd4}, 3'd2, 1'b1, 0);
    $display("test three vertex thread done");
    slow <= 1'b0;
    thread({1'b0, 6'd0, 1'b0, 6'd63, 1'b0, 6'd63, 1'b0, 6'd63, 4'd15}, 3'd0, 1'b1, 200);
    $display("test full buffer thread done");
    thread({1'b0, 6'd9, 1'b0, 6'd1, 1'b0, 6'd2, 1'b0, 6'd3, 4'd7}, 3'd3, 1'b0, 0);
    rc(vtp_pkg::OFF_THREADS, 32'h3);
    $display("test disabled stage done");
    conclude();
  end
endmodule
